// >>> rtl/ivt_cfg.svh
`ifndef IVT_CFG_SVH
`define IVT_CFG_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IVT_REG_ORB     4'h0
`define IVT_REG_PORT_B_DIRECTION    4'h2
`define IVT_REG_T1CL    4'h4
`define IVT_REG_T1CH    4'h5
`define IVT_REG_T1LL    4'h6
`define IVT_REG_T1LH    4'h7
`define IVT_REG_T2CL    4'h8
`define IVT_REG_T2CH    4'h9
`define IVT_REG_SR      4'hA
`define IVT_REG_ACR     4'hB
`define IVT_REG_PCR     4'hC
`define IVT_REG_IFR     4'hD
`define IVT_REG_IER     4'hE
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IVT_ACR_T1_OUT  7
`define IVT_ACR_T1_FREE 6
`define IVT_ACR_T2_CNT  5
`define IVT_ACR_SR_HI   4
`define IVT_ACR_SR_LO   2
`define IVT_IFR_IRQ     7
`define IVT_IFR_T1      6
`define IVT_IFR_T2      5
`define IVT_IFR_SR      2
`define IVT_IER_SET     7
`define IVT_PB_TIMER    7
// ----------------------------------------------------------------
// shift modes
// ----------------------------------------------------------------
`define IVT_SM_OFF      3'h0
`define IVT_SM_IN_T2    3'h1
`define IVT_SM_IN_SYS   3'h2
`define IVT_SM_IN_EXT   3'h3
`define IVT_SM_OUT_FREE 3'h4
`define IVT_SM_OUT_T2   3'h5
`define IVT_SM_OUT_SYS  3'h6
`define IVT_SM_OUT_EXT  3'h7
// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define IVT_RST_BYTE    8'h00
`define IVT_SR_LAST     3'h7
`define IVT_HALF_EXTRA  9'h002
`define IVT_HALF_SYS    9'h001
`endif

// >>> rtl/ivt_pkg.sv
package ivt_pkg;
  // processor bus request, one cycle per access
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic [3:0] rs;
    logic [7:0] wdata;
  } ivt_bus_t;
  // shift sequencer for internally clocked modes
  typedef enum logic [0:0] {SH_IDLE, SH_RUN} ivt_sh_state_t;
endpackage

// >>> rtl/ivt_timers.sv
`timescale 1ns/1ps
`include "ivt_cfg.svh"
// Behaviour
// RQ1: free-run zero sets flag, toggles pin
// RQ2: free-run zero reloads counter from latches
// RQ3: t1 flag cleared by write/read/direct
// RQ4: high counter write restarts timer
// RQ5: latch writes leave running count alone
// RQ6: pulse pin timer only when both bits
// RQ7: acr bit picks interval or pulse counting
// RQ8: timer 2 sixteen-bit latch/counter registers
// RQ9: one-shot flag once per high write
// RQ10: t2 flag cleared by read low/write high
// RQ11: pulse mode counts falls, flag once
// RQ12: counted pulse held low across edge
// RQ13: shift register with modulo-8 bit counter
// RQ14: acr bits 4..2 select shift mode
// RQ15: out msb first rotating, in at lsb
// RQ16: mode off stops shifting, flag zero
// RQ17: mode 001 rate from t2 latch
// RQ18: shift-in capture after rise, flag after 8
// RQ19: system-rate shift-in, stop after eight
// RQ20: external clock, flag every 8, keep shifting
// RQ21: irq pin low on enabled flag
// RQ22: flag register bit 7 shows irq
// RQ23: writing one to flag bit clears it
// RQ24: shift half period latch plus two
module ivt_timers #(
  parameter int TIMER_W = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire ivt_pkg::ivt_bus_t bus_i,
  output logic [7:0]            rdata_o,
  input  wire logic             pulse_count_pin_i,
  output logic                  timer_pulse_pin_o,
  output logic                  timer_pulse_pin_oe_o,
  input  wire logic             shift_clock_link_i,
  output logic                  shift_clock_pin_o,
  output logic                  shift_clock_pin_oe_o,
  input  wire logic             shift_data_pin_i,
  output logic                  shift_data_pin_o,
  output logic                  shift_data_pin_oe_o,
  output logic                  irq_pin_o,
  output logic                  irq_pin_oe_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (TIMER_W != 16)
  begin : g_bad_width
    $error("ivt_timers: counters are built from two bytes");
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0]         wd;
  logic [7:0]         orb_r;
  logic [7:0]         port_b_direction_r;
  logic [7:0]         acr_r;
  logic [7:0]         pcr_r;
  logic [6:0]         ier_r;
  logic [7:0]         t1_lat_lo_r;
  logic [7:0]         t1_lat_hi_r;
  logic [TIMER_W-1:0] t1_cnt_r;
  logic               t1_armed_r;
  logic               t1_out_r;
  logic               t1_flag_r;
  logic [7:0]         t2_lat_lo_r;
  logic [TIMER_W-1:0] t2_cnt_r;
  logic               t2_armed_r;
  logic               t2_flag_r;
  logic [7:0]         sr_r;
  logic               sr_flag_r;

  function automatic logic wr_hit(input ivt_pkg::ivt_bus_t b, input logic [3:0] a);
    wr_hit = b.cs && !b.rd && (b.rs == a);
  endfunction

  function automatic logic rd_hit(input ivt_pkg::ivt_bus_t b, input logic [3:0] a);
    rd_hit = b.cs && b.rd && (b.rs == a);
  endfunction

  assign wd = bus_i.wdata;

  // plain control registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      orb_r  <= `IVT_RST_BYTE;
      port_b_direction_r <= `IVT_RST_BYTE;
      acr_r  <= `IVT_RST_BYTE;
      pcr_r  <= `IVT_RST_BYTE;
    end
    else
    begin
      if (wr_hit(bus_i, `IVT_REG_ORB))  orb_r  <= wd;
      if (wr_hit(bus_i, `IVT_REG_PORT_B_DIRECTION)) port_b_direction_r <= wd;
      if (wr_hit(bus_i, `IVT_REG_ACR))  acr_r  <= wd;
      if (wr_hit(bus_i, `IVT_REG_PCR))  pcr_r  <= wd;
    end
  end

  // ----------------------------------------------------------------
  // timer 1
  // ----------------------------------------------------------------
  logic t1_free;
  logic t1_ch_wr;
  logic t1_timeout;

  assign t1_free    = acr_r[`IVT_ACR_T1_FREE];
  assign t1_ch_wr   = wr_hit(bus_i, `IVT_REG_T1CH);
  assign t1_timeout = (t1_cnt_r == '0) && !t1_ch_wr && (t1_free || t1_armed_r);

  // latches; low counter and latch writes share one low latch
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      t1_lat_lo_r <= `IVT_RST_BYTE;
      t1_lat_hi_r <= `IVT_RST_BYTE;
    end
    else
    begin
      if (wr_hit(bus_i, `IVT_REG_T1CL) || wr_hit(bus_i, `IVT_REG_T1LL))
        t1_lat_lo_r <= wd;
      if (t1_ch_wr || wr_hit(bus_i, `IVT_REG_T1LH))
        t1_lat_hi_r <= wd;
    end
  end

  // counter, arm and output level
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      t1_cnt_r   <= '0;
      t1_armed_r <= 1'b0;
      t1_out_r   <= 1'b1;
    end
    // RQ4 restart on high write
    else if (t1_ch_wr)
    begin
      t1_cnt_r   <= {wd, t1_lat_lo_r};
      t1_armed_r <= 1'b1;
      t1_out_r   <= 1'b0;
    end
    // RQ2 reload from latches
    else if (t1_free && (t1_cnt_r == '0))
    begin
      t1_cnt_r <= {t1_lat_hi_r, t1_lat_lo_r};
      // RQ1 invert pin on timeout
      t1_out_r <= ~t1_out_r;
    end
    else
    begin
      // RQ5 latch writes land here and leave the count running
      t1_cnt_r <= t1_cnt_r - 1'b1;
      if (t1_timeout)
      begin
        t1_armed_r <= 1'b0;
        t1_out_r   <= 1'b1;
      end
    end
  end

  // RQ3 flag clears, set wins
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      t1_flag_r <= 1'b0;
    else if (t1_timeout)
      t1_flag_r <= 1'b1;
    else if (t1_ch_wr || rd_hit(bus_i, `IVT_REG_T1CL) ||
             (wr_hit(bus_i, `IVT_REG_IFR) && wd[`IVT_IFR_T1]))
      t1_flag_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // timer 2
  // ----------------------------------------------------------------
  logic pc_s1_r;
  logic pc_s2_r;
  logic pc_s3_r;
  logic t2_ch_wr;
  logic t2_tick;
  logic t2_timeout;

  // RQ12 pin synchronised before edge detect
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pc_s1_r <= 1'b1;
      pc_s2_r <= 1'b1;
      pc_s3_r <= 1'b1;
    end
    else
    begin
      pc_s1_r <= pulse_count_pin_i;
      pc_s2_r <= pc_s1_r;
      pc_s3_r <= pc_s2_r;
    end
  end

  assign t2_ch_wr = wr_hit(bus_i, `IVT_REG_T2CH);
  // RQ7 interval or pulse counting
  assign t2_tick    = acr_r[`IVT_ACR_T2_CNT] ? (pc_s3_r && !pc_s2_r) : 1'b1;
  assign t2_timeout = t2_armed_r && (t2_cnt_r == '0) && !t2_ch_wr;

  // RQ8 write-only low latch
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      t2_lat_lo_r <= `IVT_RST_BYTE;
    else if (wr_hit(bus_i, `IVT_REG_T2CL))
      t2_lat_lo_r <= wd;
  end

  // RQ11 counting keeps going past zero
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      t2_cnt_r   <= '0;
      t2_armed_r <= 1'b0;
    end
    else if (t2_ch_wr)
    begin
      t2_cnt_r   <= {wd, t2_lat_lo_r};
      t2_armed_r <= 1'b1;
    end
    else
    begin
      if (t2_tick)
        t2_cnt_r <= t2_cnt_r - 1'b1;
      // RQ9 one flag per high write
      if (t2_timeout)
        t2_armed_r <= 1'b0;
    end
  end

  // RQ10 flag clears, set wins
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      t2_flag_r <= 1'b0;
    else if (t2_timeout)
      t2_flag_r <= 1'b1;
    else if (t2_ch_wr || rd_hit(bus_i, `IVT_REG_T2CL) ||
             (wr_hit(bus_i, `IVT_REG_IFR) && wd[`IVT_IFR_T2]))
      t2_flag_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // shift clock link domain
  // ----------------------------------------------------------------
  logic lk_bit_r;
  logic lk_tog_r;
  logic tg_s1_r;
  logic tg_s2_r;
  logic tg_s3_r;

  // captures the data bit and flags each external rising edge
  always_ff @(posedge shift_clock_link_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lk_bit_r <= 1'b0;
      lk_tog_r <= 1'b0;
    end
    else
    begin
      lk_bit_r <= shift_data_pin_i;
      lk_tog_r <= ~lk_tog_r;
    end
  end

  // toggle synchroniser; the bit stays stable a whole link period
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
    end
    else
    begin
      tg_s1_r <= lk_tog_r;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  logic [2:0]              sr_mode;
  logic                    sr_acc;
  logic                    sr_int;
  logic                    sr_ext;
  logic                    ext_ev;
  logic                    sd_s1_r;
  logic                    sd_s2_r;
  ivt_pkg::ivt_sh_state_t  sh_state_r;
  logic [8:0]              div_r;
  logic [8:0]              div_nxt;
  logic                    sclk_r;
  logic                    int_rise;
  logic                    int_fall;
  logic [2:0]              rise_d_r;
  logic                    done_r;
  logic [1:0]              done_d_r;
  logic [2:0]              bitcnt_r;
  logic                    sd_out_r;

  // RQ14 mode field decode
  assign sr_mode = acr_r[`IVT_ACR_SR_HI:`IVT_ACR_SR_LO];
  assign sr_acc  = bus_i.cs && (bus_i.rs == `IVT_REG_SR);
  assign sr_ext  = (sr_mode == `IVT_SM_IN_EXT) || (sr_mode == `IVT_SM_OUT_EXT);
  assign sr_int  = (sr_mode != `IVT_SM_OFF) && !sr_ext;
  assign ext_ev  = sr_ext && (tg_s2_r != tg_s3_r);
  // RQ24 timer-rate half period is latch plus two
  assign div_nxt = (sr_mode == `IVT_SM_IN_SYS || sr_mode == `IVT_SM_OUT_SYS) ?
                   (`IVT_HALF_SYS - 9'h001) : ({1'b0, t2_lat_lo_r} + `IVT_HALF_EXTRA - 9'h001);
  assign int_fall = (sh_state_r == ivt_pkg::SH_RUN) && sr_int && (div_r == '0) && sclk_r;
  assign int_rise = (sh_state_r == ivt_pkg::SH_RUN) && sr_int && (div_r == '0) && !sclk_r;

  // data input synchroniser for internally clocked shift-in
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sd_s1_r <= 1'b0;
      sd_s2_r <= 1'b0;
    end
    else
    begin
      sd_s1_r <= shift_data_pin_i;
      sd_s2_r <= sd_s1_r;
    end
  end

  // internal clock sequencer
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sh_state_r <= ivt_pkg::SH_IDLE;
      div_r      <= '0;
      sclk_r     <= 1'b1;
      rise_d_r   <= 3'h0;
      done_r     <= 1'b0;
      done_d_r   <= 2'h0;
    end
    else
    begin
      // bit and end strobes wait out the data synchroniser delay
      rise_d_r <= {rise_d_r[1:0], int_rise};
      done_d_r <= sr_int ? {done_d_r[0], done_r} : 2'h0;
      done_r   <= 1'b0;
      // RQ16 disabled mode halts shifting
      if (!sr_int)
      begin
        sh_state_r <= ivt_pkg::SH_IDLE;
        sclk_r     <= 1'b1;
      end
      // RQ17 access starts a transfer
      else if (sr_acc)
      begin
        sh_state_r <= ivt_pkg::SH_RUN;
        div_r      <= div_nxt;
        sclk_r     <= 1'b1;
      end
      else
      begin
        case (sh_state_r)
          ivt_pkg::SH_IDLE:
          begin
            sclk_r <= 1'b1;
          end
          ivt_pkg::SH_RUN:
          begin
            if (div_r == '0)
            begin
              sclk_r <= ~sclk_r;
              div_r  <= div_nxt;
              // RQ19 stop after eighth pulse
              if (!sclk_r && (bitcnt_r == `IVT_SR_LAST) && (sr_mode != `IVT_SM_OUT_FREE))
              begin
                sh_state_r <= ivt_pkg::SH_IDLE;
                done_r     <= 1'b1;
              end
            end
            else
              div_r <= div_r - 9'h001;
          end
          default:
          begin
            sh_state_r <= ivt_pkg::SH_IDLE;
          end
        endcase
      end
    end
  end

  // RQ13 modulo-8 bit counter
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bitcnt_r <= '0;
    else if (sr_acc || sr_mode == `IVT_SM_OFF)
      bitcnt_r <= '0;
    else if (int_rise || ext_ev)
      bitcnt_r <= bitcnt_r + 3'h1;
  end

  // RQ15 rotate out msb, shift in at lsb
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sr_r     <= `IVT_RST_BYTE;
      sd_out_r <= 1'b0;
    end
    else if (wr_hit(bus_i, `IVT_REG_SR))
      sr_r <= wd;
    else if (sr_mode[2] && (int_fall || ext_ev))
    begin
      sd_out_r <= sr_r[7];
      sr_r     <= {sr_r[6:0], sr_r[7]};
    end
    // RQ18 capture the level seen just before the pin rose
    else if (!sr_mode[2] && rise_d_r[2])
      sr_r <= {sr_r[6:0], sd_s2_r};
    else if (!sr_mode[2] && ext_ev)
      sr_r <= {sr_r[6:0], lk_bit_r};
  end

  // RQ20 external modes flag every eighth bit
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sr_flag_r <= 1'b0;
    else if (sr_mode == `IVT_SM_OFF)
      sr_flag_r <= 1'b0;
    else if (done_d_r[1] || (ext_ev && bitcnt_r == `IVT_SR_LAST))
      sr_flag_r <= 1'b1;
    else if (sr_acc || (wr_hit(bus_i, `IVT_REG_IFR) && wd[`IVT_IFR_SR]))
      sr_flag_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // interrupt summary and enables
  // ----------------------------------------------------------------
  logic [6:0] ifr_v;
  logic       irq_v;

  always_comb
  begin
    ifr_v               = '0;
    ifr_v[`IVT_IFR_T1]  = t1_flag_r;
    ifr_v[`IVT_IFR_T2]  = t2_flag_r;
    ifr_v[`IVT_IFR_SR]  = sr_flag_r;
  end

  // RQ22 summary of enabled flags
  assign irq_v = |(ifr_v & ier_r);

  // enable register with set/clear select in bit 7
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ier_r <= '0;
    else if (wr_hit(bus_i, `IVT_REG_IER))
      ier_r <= wd[`IVT_IER_SET] ? (ier_r | wd[6:0]) : (ier_r & ~wd[6:0]);
  end

  // ----------------------------------------------------------------
  // pins and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      timer_pulse_pin_o    <= 1'b0;
      timer_pulse_pin_oe_o <= 1'b0;
      shift_data_pin_o     <= 1'b0;
      shift_data_pin_oe_o  <= 1'b0;
      shift_clock_pin_oe_o <= 1'b0;
      shift_clock_pin_o    <= 1'b1;
      irq_pin_o            <= 1'b0;
      irq_pin_oe_o         <= 1'b0;
    end
    else
    begin
      // RQ6 timer output needs both enables
      timer_pulse_pin_o    <= (port_b_direction_r[`IVT_PB_TIMER] && acr_r[`IVT_ACR_T1_OUT]) ?
                              t1_out_r : orb_r[`IVT_PB_TIMER];
      timer_pulse_pin_oe_o <= port_b_direction_r[`IVT_PB_TIMER];
      // RQ16 off mode hands the data pin to manual control
      shift_data_pin_o     <= (sr_mode == `IVT_SM_OFF) ? pcr_r[5] : sd_out_r;
      shift_data_pin_oe_o  <= sr_mode[2] || ((sr_mode == `IVT_SM_OFF) && (pcr_r[7:6] == 2'b11));
      shift_clock_pin_o    <= sclk_r;
      shift_clock_pin_oe_o <= sr_int;
      // RQ21 open-drain request pulls low
      irq_pin_o            <= 1'b0;
      irq_pin_oe_o         <= irq_v;
    end
  end

  // registered read mux
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= `IVT_RST_BYTE;
    else if (bus_i.cs && bus_i.rd)
    begin
      case (bus_i.rs)
        `IVT_REG_ORB:  rdata_o <= orb_r;
        `IVT_REG_PORT_B_DIRECTION: rdata_o <= port_b_direction_r;
        `IVT_REG_T1CL: rdata_o <= t1_cnt_r[7:0];
        `IVT_REG_T1CH: rdata_o <= t1_cnt_r[15:8];
        `IVT_REG_T1LL: rdata_o <= t1_lat_lo_r;
        `IVT_REG_T1LH: rdata_o <= t1_lat_hi_r;
        `IVT_REG_T2CL: rdata_o <= t2_cnt_r[7:0];
        `IVT_REG_T2CH: rdata_o <= t2_cnt_r[15:8];
        `IVT_REG_SR:   rdata_o <= sr_r;
        `IVT_REG_ACR:  rdata_o <= acr_r;
        `IVT_REG_PCR:  rdata_o <= pcr_r;
        `IVT_REG_IFR:  rdata_o <= {irq_v, ifr_v};
        `IVT_REG_IER:  rdata_o <= {1'b0, ier_r};
        default:       rdata_o <= `IVT_RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_t1_free_reload: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ2
    (t1_free && t1_cnt_r == '0 && !t1_ch_wr) |=> t1_cnt_r == {$past(t1_lat_hi_r), $past(t1_lat_lo_r)})
    else $error("timer 1 did not reload from latches");

  a_t1_flag_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ1
    (t1_free && t1_timeout) |=> (t1_flag_r && (t1_out_r != $past(t1_out_r))))
    else $error("timer 1 free-run timeout missed flag or toggle");

  a_t1_flag_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ3
    (rd_hit(bus_i, `IVT_REG_T1CL) && !t1_timeout) |=> !t1_flag_r)
    else $error("timer 1 flag not cleared by low read");

  a_t1_retrigger: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ4
    t1_ch_wr |=> (t1_cnt_r == {$past(wd), $past(t1_lat_lo_r)}) && !t1_flag_r)
    else $error("timer 1 high write did not restart");

  a_t1_latch_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ5
    (wr_hit(bus_i, `IVT_REG_T1LH) && t1_cnt_r != '0) |=> t1_cnt_r == $past(t1_cnt_r) - 1'b1)
    else $error("latch write disturbed timer 1 count");

  a_pin_route: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ6
    (!port_b_direction_r[7] || !acr_r[7]) ##1 (!port_b_direction_r[7] || !acr_r[7]) |-> timer_pulse_pin_o == $past(orb_r[7]))
    else $error("timer pulse pin not following output bit");

  a_t2_once: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ9
    (!t2_armed_r && !t2_ch_wr) |=> !$rose(t2_flag_r))
    else $error("timer 2 flag set twice without rewrite");

  a_sr_off_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ16
    (sr_mode == `IVT_SM_OFF) |=> !sr_flag_r)
    else $error("shift flag set while disabled");

  a_sr_stop_eight: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ19
    done_r |-> ((sh_state_r == ivt_pkg::SH_IDLE) && (bitcnt_r == 3'h0)) ##3 (sr_flag_r || sr_acc))
    else $error("shift transfer did not stop after eight pulses");

  a_irq_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ21
    (|(ifr_v & ier_r)) |=> (irq_pin_oe_o && !irq_pin_o))
    else $error("request pin not pulled low");

endmodule

// >>> tb/ivt_serial_model.sv
`timescale 1ns/1ps
// far-side serial device: data source, link clock and pulse source
module ivt_serial_model (
  input  wire logic sclk_i,
  output logic      link_clk_o,
  output logic      data_o,
  output logic      pulse_o
);
  logic [7:0] byte_r;
  int         idx;
  // idle levels: clock high, no pulse
  initial
  begin
    link_clk_o = 1'h1;
    data_o     = 1'h0;
    pulse_o    = 1'h1;
    idx        = 8;
  end
  // arm a byte for an internally clocked transfer
  task load(input logic [7:0] b);
    byte_r = b;
    idx    = 0;
  endtask
  always @(negedge sclk_i)
  begin
    if (idx < 8)
    begin
      data_o = byte_r[7-idx];
      idx++;
    end
    else if (link_clk_o === 1'h1)
      data_o = ~data_o;
  end
  task pulse();
    pulse_o = 1'h0;
    #100;
    pulse_o = 1'h1;
    #100;
  endtask
  task send_ext(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      link_clk_o = 1'h0;
      data_o     = b[i];
      #80;
      link_clk_o = 1'h1;
      #80;
    end
    data_o = ~data_o;
  endtask
endmodule

// >>> tb/interval_timers_shift_register_bench.sv
`timescale 1ns/1ps
module interval_timers_shift_register_bench;
  logic              clock_i = 1'h0;
  logic              rst_n_i = 1'h0;
  ivt_pkg::ivt_bus_t bus     = '0;
  logic [7:0]        rdata_o;
  logic              pc, tp, tp_oe, lk, sc, sc_oe, sd_o, sd_oe, sd_m, irq, irq_oe;
  wire logic         sc_w = sc_oe ? sc : lk;
  wire logic         sd_w = sd_oe ? sd_o : sd_m;
  int                fail_count = 0;
  int                compares   = 0;
  int                cyc_n      = 0;
  always #10 clock_i = ~clock_i;
  ivt_timers dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o),
    .pulse_count_pin_i(pc), .timer_pulse_pin_o(tp), .timer_pulse_pin_oe_o(tp_oe),
    .shift_clock_link_i(sc_w), .shift_clock_pin_o(sc), .shift_clock_pin_oe_o(sc_oe),
    .shift_data_pin_i(sd_w), .shift_data_pin_o(sd_o), .shift_data_pin_oe_o(sd_oe),
    .irq_pin_o(irq), .irq_pin_oe_o(irq_oe));
  ivt_serial_model ptr_u (.sclk_i(sc_w), .link_clk_o(lk), .data_o(sd_m), .pulse_o(pc));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task results();
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // one access, then an idle cycle
  task acc(input logic r, input logic [3:0] a, input logic [7:0] d);
    bus = '{cs: 1'h1, rd: r, rs: a, wdata: d};
    cyc(1);
    bus.cs = 1'h0;
    cyc(1);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    acc(1'h1, a, 8'h00);
    chk($sformatf("reg %h", a), e, rdata_o);
  endtask
  task wait_flag(input int i);
    repeat (200)
    begin
      acc(1'h1, 4'hD, 8'h00);
      if (rdata_o[i] === 1'h1)
        break;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_timer1();
    logic p;
    acc(1'h0, 4'h2, 8'h80);
    acc(1'h0, 4'h0, 8'h80);
    chk("tpin", 8'h01, {7'h00, tp});
    chk("tpin oe", 8'h01, {7'h00, tp_oe});
    acc(1'h0, 4'h0, 8'h00);
    chk("tpin", 8'h00, {7'h00, tp});
    acc(1'h0, 4'hE, 8'hC0);
    acc(1'h0, 4'hB, 8'hC0);
    acc(1'h0, 4'h4, 8'h40);
    repeat (4)
    begin
      acc(1'h0, 4'h5, 8'h00);
      cyc(30);
    end
    rd(4'hD, 8'h00);
    wait_flag(6);
    chk("ifr", 8'hC0, rdata_o);
    cyc(2);
    chk("irq", 8'h02, {6'h00, irq_oe, irq});
    p = tp;
    acc(1'h0, 4'hD, 8'h40);
    rd(4'hD, 8'h00);
    wait_flag(6);
    chk("ifr", 8'hC0, rdata_o);
    chk("tpin", {7'h00, ~p}, {7'h00, tp});
    acc(1'h1, 4'h4, 8'h00);
    rd(4'hD, 8'h00);
    acc(1'h0, 4'hE, 8'h40);
    acc(1'h0, 4'hB, 8'h00);
    acc(1'h0, 4'h4, 8'hFF);
    acc(1'h0, 4'h5, 8'hFF);
  endtask
  task t_timer2();
    acc(1'h0, 4'h8, 8'h10);
    acc(1'h0, 4'h9, 8'h00);
    cyc(40);
    rd(4'hD, 8'h20);
    acc(1'h1, 4'h8, 8'h00);
    rd(4'hD, 8'h00);
    cyc(40);
    rd(4'hD, 8'h00);
    acc(1'h0, 4'h9, 8'h00);
    cyc(40);
    rd(4'hD, 8'h20);
    acc(1'h0, 4'h9, 8'hFF);
    rd(4'hD, 8'h00);
    acc(1'h0, 4'hB, 8'h20);
    acc(1'h0, 4'h8, 8'h03);
    acc(1'h0, 4'h9, 8'h00);
    ptr_u.pulse();
    ptr_u.pulse();
    cyc(10);
    rd(4'hD, 8'h00);
    ptr_u.pulse();
    cyc(10);
    rd(4'hD, 8'h20);
    acc(1'h1, 4'h8, 8'h00);
  endtask
  // internally clocked shift-in, measuring the low half period
  task sh_in(input logic [7:0] m, input logic [7:0] b, input int h);
    int n;
    n = 0;
    acc(1'h0, 4'hB, m);
    ptr_u.load(b);
    acc(1'h1, 4'hA, 8'h00);
    repeat (50)
      if (sc !== 1'h0)
        cyc(1);
    while (sc === 1'h0 && n < 50)
    begin
      n++;
      cyc(1);
    end
    chk("half", h[7:0], n[7:0]);
    chk("sclk oe", 8'h01, {7'h00, sc_oe});
    cyc(100);
    chk("sclk", 8'h01, {7'h00, sc});
    rd(4'hD, 8'h04);
    rd(4'hA, b);
  endtask
  task t_shift();
    acc(1'h0, 4'h8, 8'h02);
    sh_in(8'h04, 8'hC3, 4);
    sh_in(8'h08, 8'hB4, 1);
    acc(1'h0, 4'hB, 8'h18);
    acc(1'h0, 4'hA, 8'h01);
    cyc(40);
    chk("sdata", 8'h03, {6'h00, sd_oe, sd_o});
    rd(4'hD, 8'h04);
    rd(4'hA, 8'h01);
    acc(1'h0, 4'hB, 8'h00);
    rd(4'hD, 8'h00);
    acc(1'h0, 4'hC, 8'hE0);
    chk("sdata", 8'h03, {6'h00, sd_oe, sd_o});
    acc(1'h0, 4'hA, 8'hA5);
    rd(4'hA, 8'hA5);
    acc(1'h0, 4'hB, 8'h0C);
    acc(1'h1, 4'hA, 8'h00);
    ptr_u.send_ext(8'h5A);
    cyc(10);
    rd(4'hD, 8'h04);
    rd(4'hA, 8'h5A);
    rd(4'hD, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clock_i)
  begin
    cyc_n++;
    if (cyc_n >= 20000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    cyc(6);
    rst_n_i = 1'h1;
    t_timer1();
    t_timer2();
    t_shift();
    results();
  end
endmodule
